// ===== rtl/dco_clkout.sv
/*
 * Divided clock output unit: source select, power-of-two divider,
 * gated external output, stabilisation flags and their interrupt.
 * Assumes oscillator clocks and events arrive synchronous to clk_sys.
 */
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps

// Contract
// - Output drives divided clock only while enabled
// - Select code picks internal, crystal or system
// - Internal oscillator divides by two to the n
// - Crystal codes four up give large ratios
// - System source output stops during sleep, halt
// - Enable gating unsynchronised; shortened pulse possible
// - Enable bits pass stabilisation events to irq
// - Stable flags set on event, clear by one
module dco_clkout
  import dco_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic internal_osc_clock,
  input wire logic crystal_osc_clock,
  input wire logic standby,
  input wire logic internal_osc_stable_evt,
  input wire logic crystal_stable_evt,
  output logic divided_clock_out,
  output logic irq
);

  // ************************************************************
  // Reset release
  // ************************************************************
  // Assert at once, release after two edges to keep recovery time clean
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ************************************************************
  // State
  // ************************************************************
  dco_state_t s_q;
  dco_state_t s_d;

  localparam dco_state_t DCO_STATE_RST = '{
    ctrl: '{
      clkout_divider: DCO_DIV_RST,
      clkout_source_select: dco_src_t'(DCO_SRC_RST),
      clkout_enable: DCO_EN_RST
    },
    flags: DCO_FLAGS_RST,
    irq_en: DCO_IRQEN_RST,
    cnt: 15'h0000,
    iosc_prev: 1'b0,
    osc1_prev: 1'b0,
    clk_out: 1'b0,
    irq: 1'b0,
    rdata: 16'h0000
  };

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Exponent k of the ratio 2^k; reserved source codes take the divider code as k
  function automatic logic [3:0] div_shift(input dco_src_t src, input logic [2:0] div);
    logic [3:0] sh;
    sh = {1'b0, div};
    case (src)
      DCO_SRC_IOSC:
      begin
        sh = {1'b0, div};
      end
      DCO_SRC_OSC1:
      begin
        case (div)
          3'h4: sh = 4'h8;
          3'h5: sh = 4'ha;
          3'h6: sh = 4'hc;
          3'h7: sh = 4'hf;
          default: sh = {1'b0, div};
        endcase
      end
      DCO_SRC_SYS:
      begin
        sh = 4'h0;
      end
      default:
      begin
        sh = {1'b0, div};
      end
    endcase
    return sh;
  endfunction

  // Source edges per output half period, less one
  function automatic logic [14:0] half_m1_of(input logic [3:0] sh);
    logic [15:0] edges;
    logic [14:0] res;
    edges = 16'h0001;
    res = 15'h0000;
    if (sh != 4'h0)
    begin
      edges = 16'h0001 << (sh - 4'h1);
      res = 15'(edges - 16'h0001);
    end
    return res;
  endfunction

  // Control word decode; bit 1 and bits 7 up are reserved
  function automatic dco_ctrl_t ctrl_decode(input logic [15:0] w);
    dco_ctrl_t c;
    c.clkout_enable = w[DCO_EN_BIT];
    c.clkout_source_select = dco_src_t'(w[DCO_SRC_LSB +: 2]);
    c.clkout_divider = w[DCO_DIV_LSB +: 3];
    return c;
  endfunction

  // Sticky event bit: a set in the clearing cycle wins
  function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
    logic nxt;
    nxt = set | (cur & ~clr);
    return nxt;
  endfunction

  // Rising edge of a sampled oscillator level
  function automatic logic rise_of(input logic now, input logic prev);
    logic r;
    r = now & ~prev;
    return r;
  endfunction

  // Level request: any unmasked pending flag
  function automatic logic irq_of(input logic [1:0] flags, input logic [1:0] en);
    logic any;
    any = |(flags & en);
    return any;
  endfunction

  // Read word; unmapped addresses and reserved bits read zero
  function automatic logic [15:0] read_word(input logic [3:0] addr, input dco_state_t st);
    logic [15:0] w;
    w = 16'h0000;
    case (addr)
      DCO_ADDR_CTRL:
      begin
        w = {9'h000, st.ctrl.clkout_divider, st.ctrl.clkout_source_select, 1'b0,
             st.ctrl.clkout_enable};
      end
      DCO_ADDR_FLAGS:
      begin
        w = {14'h0000, st.flags};
      end
      DCO_ADDR_IRQEN:
      begin
        w = {14'h0000, st.irq_en};
      end
      default:
      begin
        w = 16'h0000;
      end
    endcase
    return w;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    dco_ctrl_t new_ctrl;
    logic [3:0] sh;
    logic [14:0] half_m1;
    logic src_level;
    logic src_edge;
    logic [1:0] clr;
    logic ctrl_wr;
    logic ctrl_changed;

    new_ctrl = s_q.ctrl;
    sh = 4'h0;
    half_m1 = 15'h0000;
    src_level = 1'b0;
    src_edge = 1'b0;
    clr = 2'h0;
    ctrl_wr = 1'b0;
    ctrl_changed = 1'b0;

    s_d = s_q;
    s_d.rdata = 16'h0000;
    s_d.iosc_prev = internal_osc_clock;
    s_d.osc1_prev = crystal_osc_clock;

    // ************************************************************
    // Register writes
    // ************************************************************
    ctrl_wr = reg_wr && reg_addr == DCO_ADDR_CTRL;
    if (ctrl_wr)
    begin
      new_ctrl = ctrl_decode(reg_wdata);
    end
    // Rewriting the same value keeps the phase running
    ctrl_changed = new_ctrl != s_q.ctrl;
    s_d.ctrl = new_ctrl;

    if (reg_wr && reg_addr == DCO_ADDR_IRQEN)
    begin
      s_d.irq_en = reg_wdata[1:0];
    end

    if (reg_wr && reg_addr == DCO_ADDR_FLAGS)
    begin
      clr = reg_wdata[1:0];
    end

    // ************************************************************
    // Stabilisation flags and interrupt
    // ************************************************************
    // Writing zero leaves a flag alone
    s_d.flags[DCO_IOSC_STABLE_BIT] = sticky_next(s_q.flags[DCO_IOSC_STABLE_BIT],
      internal_osc_stable_evt, clr[DCO_IOSC_STABLE_BIT]);
    s_d.flags[DCO_OSC1_STABLE_BIT] = sticky_next(s_q.flags[DCO_OSC1_STABLE_BIT],
      crystal_stable_evt, clr[DCO_OSC1_STABLE_BIT]);
    // Built from the next flags so the request rises with its flag
    s_d.irq = irq_of(s_d.flags, s_d.irq_en);

    // ************************************************************
    // Register reads
    // ************************************************************
    // Data stand one cycle only, zero otherwise
    if (reg_rd)
    begin
      s_d.rdata = read_word(reg_addr, s_q);
    end
    else
    begin
      s_d.rdata = 16'h0000;
    end

    // ************************************************************
    // Source selection and edge detection
    // ************************************************************
    case (s_q.ctrl.clkout_source_select)
      DCO_SRC_IOSC:
      begin
        src_level = internal_osc_clock;
        src_edge = rise_of(internal_osc_clock, s_q.iosc_prev);
      end
      DCO_SRC_OSC1:
      begin
        src_level = crystal_osc_clock;
        src_edge = rise_of(crystal_osc_clock, s_q.osc1_prev);
      end
      DCO_SRC_SYS:
      begin
        // A flop cannot repeat its own clock, so undivided means half rate
        src_level = ~s_q.clk_out;
        src_edge = ~standby;
      end
      default:
      begin
        src_level = 1'b0;
        src_edge = 1'b0;
      end
    endcase
    sh = div_shift(s_q.ctrl.clkout_source_select, s_q.ctrl.clkout_divider);
    half_m1 = half_m1_of(sh);

    // ************************************************************
    // Divider and output gating
    // ************************************************************
    // Gating takes effect at once, phase not waited for
    if (!s_q.ctrl.clkout_enable || ctrl_changed)
    begin
      s_d.cnt = 15'h0000;
      s_d.clk_out = 1'b0;
    end
    else if (s_q.ctrl.clkout_source_select == DCO_SRC_SYS && standby)
    begin
      s_d.clk_out = s_q.clk_out;
    end
    else if (sh == 4'h0)
    begin
      // Undivided source follows its own level one cycle late
      s_d.clk_out = src_level;
    end
    else if (src_edge)
    begin
      // Counter only advances on source rising edges
      if (s_q.cnt == half_m1)
      begin
        s_d.cnt = 15'h0000;
        s_d.clk_out = ~s_q.clk_out;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 15'h0001;
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Low clock enable freezes every field, outputs included
  always_ff @(posedge clk_sys or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      s_q <= DCO_STATE_RST;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata = s_q.rdata;
  assign divided_clock_out = s_q.clk_out;
  assign irq = s_q.irq;

endmodule // dco_clkout

// ===== rtl/dco_pkg.sv
/*
 * Constants, register map and state layout of the divided clock output unit.
 * Assumes one 20 MHz system clock and a 16-bit register port.
 */
package dco_pkg;

  // ************************************************************
  // Register map (word index on the register port)
  // ************************************************************
  localparam logic [3:0] DCO_ADDR_CTRL = 4'h0;
  localparam logic [3:0] DCO_ADDR_FLAGS = 4'h1;
  localparam logic [3:0] DCO_ADDR_IRQEN = 4'h2;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int DCO_EN_BIT = 0;
  localparam int DCO_SRC_LSB = 2;
  localparam int DCO_DIV_LSB = 4;
  localparam int DCO_IOSC_STABLE_BIT = 0;
  localparam int DCO_OSC1_STABLE_BIT = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic DCO_EN_RST = 1'b0;
  localparam logic [1:0] DCO_SRC_RST = 2'h0;
  localparam logic [2:0] DCO_DIV_RST = 3'h0;
  localparam logic [1:0] DCO_FLAGS_RST = 2'h0;
  localparam logic [1:0] DCO_IRQEN_RST = 2'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int DCO_CLK_MHZ = 20;
  localparam int DCO_CLK_PERIOD_NS = 1000 / DCO_CLK_MHZ;

  // ************************************************************
  // Source codes
  // ************************************************************
  typedef enum logic [1:0] {
    DCO_SRC_IOSC = 2'b00,
    DCO_SRC_OSC1 = 2'b01,
    DCO_SRC_NONE = 2'b10,
    DCO_SRC_SYS = 2'b11
  } dco_src_t;

  typedef struct packed {
    logic [2:0] clkout_divider;
    dco_src_t clkout_source_select;
    logic clkout_enable;
  } dco_ctrl_t;

  typedef struct packed {
    dco_ctrl_t ctrl;
    logic [1:0] flags;
    logic [1:0] irq_en;
    logic [14:0] cnt;
    logic iosc_prev;
    logic osc1_prev;
    logic clk_out;
    logic irq;
    logic [15:0] rdata;
  } dco_state_t;

endpackage

// ===== tb/dco_clkout_checker.sv
/* Port checker of dco_clkout, bound to every instance.
   Assumes clk_en held high. */
`timescale 1ns/1ps
module dco_clkout_checker
  import dco_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic internal_osc_clock,
  input wire logic crystal_osc_clock,
  input wire logic standby,
  input wire logic internal_osc_stable_evt,
  input wire logic crystal_stable_evt,
  input wire logic divided_clock_out,
  input wire logic irq
);
  // Shadow of ctrl: bit0 enable, 2:1 source, 5:3 divider
  logic [5:0] sh_q;
  wire logic c_wr = reg_wr && clk_en && reg_addr == DCO_ADDR_CTRL;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      sh_q <= 6'h00;
    else if (c_wr)
      sh_q <= {reg_wdata[6:2], reg_wdata[0]};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_dis_low: assert property ($past(c_wr && !reg_wdata[0]) |-> !divided_clock_out)
    else $error("output not low after disable");
  chk_iosc_pass: assert property (sh_q == 6'h01 && !$past(c_wr) && !$past(c_wr, 2)
    |-> divided_clock_out == $past(internal_osc_clock)) else $error("undivided mismatch");
  chk_src_none: assert property (sh_q[2:1] == 2'h2 && !$past(c_wr) |-> !divided_clock_out)
    else $error("no-source output not low");
  chk_sys_stop: assert property ($past(standby && !c_wr && sh_q[2:1] == 2'h3)
    |-> $stable(divided_clock_out)) else $error("output moved in standby");
  chk_irq_off: assert property ($past(reg_wr && reg_addr == DCO_ADDR_IRQEN
    && reg_wdata[1:0] == 2'h0) |-> !irq) else $error("irq while masked");
  chk_irq_rise: assert property ($rose(irq) |-> $past(internal_osc_stable_evt
    || crystal_stable_evt || reg_wr && reg_addr == DCO_ADDR_IRQEN)) else $error("irq uncaused");
  chk_flag_read: assert property ($past(internal_osc_stable_evt, 2)
    && $past(reg_rd && reg_addr == DCO_ADDR_FLAGS) |-> reg_rdata[0]) else $error("flag lost");
  chk_ctrl_read: assert property ($past(reg_rd && reg_addr == DCO_ADDR_CTRL)
    |-> reg_rdata == {9'h000, sh_q[5:1], 1'b0, sh_q[0]}) else $error("ctrl readback");
endmodule // dco_clkout_checker
bind dco_clkout dco_clkout_checker i_dco_clkout_checker (.*);

// ===== tb/dco_rx.sv
/* Receiver at the clock output pin: counts rises, measures the last period.
   Assumes the pin changes only on clk_sys edges. */
`timescale 1ns/1ps
module dco_rx
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic pin,
  output logic [31:0] period,
  output logic [15:0] n_rise
);
  logic prev_q;
  logic [31:0] cnt_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_q <= 1'b0;
      cnt_q <= 32'h0;
      period <= 32'h0;
      n_rise <= 16'h0;
    end
    else
    begin
      prev_q <= pin;
      cnt_q <= cnt_q + 32'h1;
      // Short pulses count too, a real input would see them
      if (pin && !prev_q)
      begin
        period <= cnt_q;
        cnt_q <= 32'h1;
        n_rise <= n_rise + 16'h1;
      end
    end
  end
endmodule // dco_rx

// ===== tb/tb_top.sv
/* Self-checking bench of dco_clkout with a period-measuring receiver.
   Assumes 20 MHz clk_sys; oscillator inputs toggle every cycle. */
`timescale 1ns/1ps
module tb_top
  import dco_pkg::*;
;
  logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, osc = 1'b0;
  logic standby = 1'b0, ev_i = 1'b0, ev_c = 1'b0, ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, n_rise, n0;
  logic [31:0] per;
  logic pin, irq;
  int n_errors = 0, n_tests = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  dco_clkout i_dco_clkout (.clk_sys(clk_sys), .rstn(rstn), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .internal_osc_clock(osc), .crystal_osc_clock(~osc), .standby(standby),
    .internal_osc_stable_evt(ev_i), .crystal_stable_evt(ev_c), .divided_clock_out(pin),
    .irq(irq));
  dco_rx i_dco_rx (.clk_sys(clk_sys), .rstn(rstn), .pin(pin), .period(per), .n_rise(n_rise));
  task automatic end_sim();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(string nm, logic [3:0] a, logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 cmp(nm, {16'h0, e}, {16'h0, reg_rdata});
    @(posedge clk_sys);
  endtask
  // Three rises so the measured period lies wholly after the restart
  task automatic meas(logic [15:0] c, int k);
    wr(DCO_ADDR_CTRL, c);
    n0 = n_rise;
    wait (n_rise == n0 + 16'h3);
    #1 cmp("period", 32'h1 << (k + 1), per);
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys)
  begin
    osc <= ~osc;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd("ctrl", DCO_ADDR_CTRL, 16'h0000);
    rd("irqen", DCO_ADDR_IRQEN, 16'h0000);
    // Frozen by clock enable: the write must not land
    ce <= 1'b0;
    wr(DCO_ADDR_CTRL, 16'h0011);
    ce <= 1'b1;
    rd("ctrl frozen", DCO_ADDR_CTRL, 16'h0000);
    ev_i <= 1'b1;
    @(posedge clk_sys);
    ev_i <= 1'b0;
    rd("flags", DCO_ADDR_FLAGS, 16'h0001);
    cmp("irq masked", 0, irq);
    wr(DCO_ADDR_FLAGS, 16'h0000);
    rd("flags kept", DCO_ADDR_FLAGS, 16'h0001);
    wr(DCO_ADDR_IRQEN, 16'h0003);
    #1 cmp("irq", 1, irq);
    @(posedge clk_sys);
    wr(DCO_ADDR_FLAGS, 16'h0001);
    #1 cmp("irq clear", 0, irq);
    @(posedge clk_sys);
    ev_c <= 1'b1;
    @(posedge clk_sys);
    ev_c <= 1'b0;
    #1 cmp("irq crystal", 1, irq);
    @(posedge clk_sys);
    wr(DCO_ADDR_FLAGS, 16'h0002);
    rd("flags clear", DCO_ADDR_FLAGS, 16'h0000);
    for (int d = 0; d < 8; d++)
      meas(16'(16'h0001 | d << 4), d);
    for (int d = 0; d < 7; d++)
      meas(16'(16'h0005 | d << 4), d < 4 ? d : 2 * d);
    // Sys source only at divider 0, clk_sys over two
    meas(16'h000d, 0);
    // Let the last pre-standby rise reach the counter before sampling it
    standby <= 1'b1;
    repeat (3) @(posedge clk_sys);
    n0 = n_rise;
    repeat (20) @(posedge clk_sys);
    cmp("standby rises", {16'h0, n0}, {16'h0, n_rise});
    standby <= 1'b0;
    wr(DCO_ADDR_CTRL, 16'h0010);
    repeat (4)
    begin
      #1 cmp("pin off", 0, pin);
      @(posedge clk_sys);
    end
    wr(DCO_ADDR_CTRL, 16'h0009);
    repeat (4)
    begin
      #1 cmp("no source", 0, pin);
      @(posedge clk_sys);
    end
    end_sim();
  end
endmodule // tb_top
